//--- logic/xc_pkg.sv
// xc_pkg: constants and types shared by the vc-4 cross-connect and its path end
// assumes both ends run on one 100 MHz pclk; widths fixed at four ports
package xc_pkg;
	// ports and frame structure
	localparam int N_PORT          = 4;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FRAME_TIME_NS   = 125000;
	localparam int FRAME_CYCLES    = FRAME_TIME_NS / CLK_PERIOD_NS;
	localparam int VC4_BYTES       = 2349;
	localparam int LINK_DIV        = 4;
	localparam int LINK_RX_PHASE   = 2;
	// protection timing
	localparam int SWITCH_TIME_MS  = 50;
	localparam int HO_STEP_MS      = 100;
	localparam int HO_STEP_FRAMES  = HO_STEP_MS * 1000000 / FRAME_TIME_NS;
	localparam int HO_MAX_S        = 10;
	localparam int HO_MAX_STEPS    = HO_MAX_S * 1000 / HO_STEP_MS;
	localparam int WTR_UNIT_S      = 60;
	localparam int WTR_UNIT_FRAMES = WTR_UNIT_S * 1000000 / (FRAME_TIME_NS / 1000);
	localparam int WTR_MIN_MINUTES = 5;
	localparam int WTR_MAX_MINUTES = 12;
	// register offsets
	localparam logic [31:0] CMD_ADDR    = 32'h0000_0000;
	localparam logic [31:0] TIMER_ADDR  = 32'h0000_0004;
	localparam logic [31:0] STATUS_ADDR = 32'h0000_0008;
	localparam logic [31:0] SLOT_ADDR   = 32'h0000_000c;
	// command word fields
	localparam int CMD_OP_LSB     = 0;
	localparam int CMD_OUT_LSB    = 4;
	localparam int CMD_IN_LSB     = 6;
	localparam int CMD_PIN_LSB    = 8;
	localparam int CMD_PROT_BIT   = 10;
	localparam int CMD_PTYPE_LSB  = 11;
	localparam int CMD_BIDIR_BIT  = 13;
	localparam int CMD_SLOT_LSB   = 14;
	localparam int CMD_OWNER_LSB  = 16;
	localparam int CMD_SINK_BIT   = 18;
	localparam int CMD_EXT_LSB    = 19;
	localparam int CMD_TGT_BIT    = 22;
	// timer word fields
	localparam int TMR_HO_LSB     = 0;
	localparam int TMR_WTR_LSB    = 8;
	localparam int TMR_REV_BIT    = 12;
	localparam int TMR_OUT_LSB    = 16;
	// status and slot word fields
	localparam int ST_SEL_LSB     = 0;
	localparam int ST_ON_LSB      = 4;
	localparam int ST_FAULT_LSB   = 8;
	localparam int ST_REFUSED_BIT = 12;
	localparam int SL_ON_LSB      = 0;
	localparam int SL_OWN_LSB     = 4;
	// reset values of a fresh connection
	localparam logic [6:0] HO_RST  = 7'h00;
	localparam logic [3:0] WTR_RST = 4'(WTR_MIN_MINUTES);
	localparam logic       REV_RST = 1'b1;

	typedef enum logic [2:0] {
		op_none, op_connect, op_disconnect, op_claim, op_release, op_sink, op_ext
	} op_t;
	typedef enum logic [2:0] {
		ext_none, clear_cmd, lockout_cmd, forced_switch_cmd, manual_switch_cmd
	} external_command_t;
	typedef enum logic [1:0] {
		inherent_monitored_protection,
		nonintrusive_monitored_protection,
		sublayer_monitored_protection
	} protection_type_t;

	// one matrix connection, kept per output point
	typedef struct packed {
		logic              on;
		logic [1:0]        src;
		logic              connection_type;
		logic [1:0]        prot_src;
		protection_type_t  protection_type;
		logic              traffic_direction;
		logic              operation_type;
		logic [6:0]        hold_off_time;
		logic [3:0]        wait_to_restore_time;
		external_command_t external_command;
		logic              tgt;
		logic              sel;
	} conn_t;
endpackage

//--- logic/xc_link_if.sv
// xc_link_if: byte streams between path ends and the cross-connect
// assumes the far end drives the link clock, frame start and all inputs
`timescale 1ns/100ps
interface xc_link_if;
	logic                                 timing_clock_in;
	logic                                 frame_start;
	logic [xc_pkg::N_PORT-1:0][7:0]       in_data;
	logic [xc_pkg::N_PORT-1:0]            server_signal_fail_in;
	logic [xc_pkg::N_PORT-1:0]            trail_signal_fail_in;
	logic [xc_pkg::N_PORT-1:0]            trail_signal_degrade_in;
	logic [xc_pkg::N_PORT-1:0][7:0]       out_data;
	logic [xc_pkg::N_PORT-1:0]            out_fs;
	logic [xc_pkg::N_PORT-1:0]            out_ssf;

	modport device (
		input  timing_clock_in, frame_start, in_data, server_signal_fail_in,
		input  trail_signal_fail_in, trail_signal_degrade_in,
		output out_data, out_fs, out_ssf
	);
	modport far (
		output timing_clock_in, frame_start, in_data, server_signal_fail_in,
		output trail_signal_fail_in, trail_signal_degrade_in,
		input  out_data, out_fs, out_ssf
	);
endinterface

//--- logic/xc_path_end.sv
// xc_path_end: path-end side of the link; frames bytes and makes the link clock
// assumes the user presents src_byte before each byte_take pulse
`timescale 1ns/100ps
module xc_path_end #(
	parameter int FRAME_CYCLES = xc_pkg::FRAME_CYCLES
) (
	// clock and reset
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	// link
	xc_link_if.far                               link,
	// source side
	input  wire logic [xc_pkg::N_PORT-1:0][7:0]  src_byte,
	input  wire logic [xc_pkg::N_PORT-1:0]       src_server_fail,
	input  wire logic [xc_pkg::N_PORT-1:0]       src_trail_fail,
	input  wire logic [xc_pkg::N_PORT-1:0]       src_trail_degrade,
	output logic                                 byte_take,
	output logic [11:0]                          byte_index,
	// sink side
	output logic [xc_pkg::N_PORT-1:0][7:0]       rx_byte,
	output logic [xc_pkg::N_PORT-1:0]            rx_fs,
	output logic [xc_pkg::N_PORT-1:0]            rx_ssf,
	output logic                                 rx_valid
);
	localparam int NP = xc_pkg::N_PORT;

	typedef struct packed {
		logic [13:0]         cyc;
		logic                lclk;
		logic                fs;
		logic [NP-1:0][7:0]  data;
		logic [NP-1:0]       ssf;
		logic [NP-1:0]       tsf;
		logic [NP-1:0]       tsd;
		logic                take;
		logic [11:0]         index;
		logic [NP*10-1:0]    sy1;
		logic [NP*10-1:0]    sy2;
		logic [NP-1:0][7:0]  rxb;
		logic [NP-1:0]       rxf;
		logic [NP-1:0]       rxs;
		logic                rxv;
	} st_t;

	st_t                 s;
	st_t                 n;
	logic [NP-1:0][7:0]  sy_data;
	logic [NP-1:0]       sy_fs;
	logic [NP-1:0]       sy_ssf;

	assign {sy_data, sy_fs, sy_ssf} = s.sy2;

	// byte timing, launch and capture
	always_comb begin
		logic [13:0] k;
		logic [13:0] phase;
		logic        in_frame;
		k = s.cyc / 14'(xc_pkg::LINK_DIV);
		phase = s.cyc % 14'(xc_pkg::LINK_DIV);
		in_frame = k < 14'(xc_pkg::VC4_BYTES);
		n = s;
		n.cyc = (s.cyc == 14'(FRAME_CYCLES - 1)) ? 14'h0000 : s.cyc + 14'h0001;
		// clock stands still between the last byte and the next frame
		n.lclk = in_frame && (phase < 14'(xc_pkg::LINK_DIV / 2));
		n.take = 1'b0;
		n.rxv = 1'b0;
		if (in_frame && phase == 14'h0000) begin
			n.data = src_byte;
			n.fs = (k == 14'h0000);
			n.ssf = src_server_fail;
			n.tsf = src_trail_fail;
			n.tsd = src_trail_degrade;
			n.take = 1'b1;
			n.index = k[11:0];
		end
		// device outputs are other logic: two flip-flops before use
		n.sy1 = {link.out_data, link.out_fs, link.out_ssf};
		n.sy2 = s.sy1;
		// sampled mid-way, clear of the device's update instant
		if (phase == 14'(xc_pkg::LINK_RX_PHASE) && k != 14'h0000
				&& k <= 14'(xc_pkg::VC4_BYTES)) begin
			n.rxb = sy_data;
			n.rxf = sy_fs;
			n.rxs = sy_ssf;
			n.rxv = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// outputs straight from state
	assign link.timing_clock_in = s.lclk;
	assign link.frame_start = s.fs;
	assign link.in_data = s.data;
	assign link.server_signal_fail_in = s.ssf;
	assign link.trail_signal_fail_in = s.tsf;
	assign link.trail_signal_degrade_in = s.tsd;
	assign byte_take = s.take;
	assign byte_index = s.index;
	assign rx_byte = s.rxb;
	assign rx_fs = s.rxf;
	assign rx_ssf = s.rxs;
	assign rx_valid = s.rxv;
endmodule

//--- logic/xc_matrix.sv
// xc_matrix: vc-4 cross-connect with 1+1 subnetwork protection selectors
// assumes an apb master for management and the path end driving the link
//
// Contract
// - byte streams framed every 125 us
// - overhead present or signal is unequipped
// - generated unequipped signal has zero tandem byte
// - client and overhead bytes carried per frame
// - protection switching bits passed through untouched
// - data link and reserved bits passed untouched
// - one owner per timeslot, others refused
// - each sink report individually suppressible
// - connect and disconnect on management request
// - connection holds type, direction, point ids
// - broadcast is several connections, same input
// - reconfiguration leaves traffic undisturbed; kept only when the input stays and protection is not removed
// - unconnected output gets unequipped, fail clear
// - sink selector picks working or protection
// - source side bridges to both outputs
// - linear 1+1 unidirectional, switch within 50 ms
// - revertive return after wait-to-restore
// - hold-off delay before acting on conditions
// - protection type selects fail and degrade
// - revertive mode accepts four commands only; op_ext stores any command in either mode
// - non-revertive commands may target either input
`timescale 1ns/100ps
module xc_matrix #(
	parameter int HO_STEP_FRAMES  = xc_pkg::HO_STEP_FRAMES,
	parameter int WTR_UNIT_FRAMES = xc_pkg::WTR_UNIT_FRAMES
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	// link
	xc_link_if.device         link
);
	localparam int NP = xc_pkg::N_PORT;

	typedef struct packed {
		logic [NP*11+1:0]             sy1;
		logic [NP*11+1:0]             sy2;
		logic                         clk_d;
		xc_pkg::conn_t [NP-1:0]       conn;
		logic [NP-1:0][16:0]          ho_w;
		logic [NP-1:0][16:0]          ho_p;
		logic [NP-1:0][23:0]          wtr_cnt;
		logic [NP-1:0]                sink_off;
		logic [NP-1:0]                slot_on;
		logic [NP-1:0][1:0]           slot_own;
		logic                         refused;
		logic [NP-1:0][7:0]           od;
		logic [NP-1:0]                ofs;
		logic [NP-1:0]                ossf;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
	} st_t;

	st_t                 s;
	st_t                 n;
	logic                lk;
	logic                fs_in;
	logic [NP-1:0][7:0]  din;
	logic [NP-1:0]       ssf;
	logic [NP-1:0]       tsf;
	logic [NP-1:0]       tsd;

	assign {lk, fs_in, din, ssf, tsf, tsd} = s.sy2;

	// a fresh connection with default timers
	function automatic xc_pkg::conn_t fresh(input logic [1:0] src);
		xc_pkg::conn_t r;
		r = '0;
		r.on = 1'b1;
		r.src = src;
		r.hold_off_time = xc_pkg::HO_RST;
		r.wait_to_restore_time = xc_pkg::WTR_RST;
		r.operation_type = xc_pkg::REV_RST;
		return r;
	endfunction

	// link sampling, selectors, data path and register access
	always_comb begin
		xc_pkg::conn_t c;
		logic          edge_seen;
		logic          frame_tick;
		logic          setup;
		logic          access;
		logic          bad;
		logic [31:0]   rd;
		logic [1:0]    a;
		logic [1:0]    b;
		logic [1:0]    o;
		logic [1:0]    src_in;
		logic [1:0]    slot;
		logic [1:0]    own;
		logic          sfw;
		logic          sdw;
		logic          sfp;
		logic          sdp;
		logic          req;
		logic          nsel;
		xc_pkg::external_command_t ext;
		n = s;
		c = '0;
		rd = 32'h0000_0000;
		a = 2'h0;
		b = 2'h0;
		o = 2'h0;
		src_in = 2'h0;
		slot = 2'h0;
		own = 2'h0;
		sfw = 1'b0;
		sdw = 1'b0;
		sfp = 1'b0;
		sdp = 1'b0;
		req = 1'b0;
		nsel = 1'b0;
		ext = xc_pkg::ext_none;
		// link pins pass two flip-flops before anything reads them
		n.sy1 = {link.timing_clock_in, link.frame_start, link.in_data,
			link.server_signal_fail_in, link.trail_signal_fail_in,
			link.trail_signal_degrade_in};
		n.sy2 = s.sy1;
		n.clk_d = lk;
		edge_seen = lk & ~s.clk_d;
		frame_tick = edge_seen & fs_in;
		for (int i = 0; i < NP; i++) begin
			c = s.conn[i];
			a = c.src;
			b = c.prot_src;
			if (c.protection_type == xc_pkg::inherent_monitored_protection) begin
				sfw = ssf[a];
				sfp = ssf[b];
				sdw = 1'b0;
				sdp = 1'b0;
			end else begin
				sfw = tsf[a];
				sfp = tsf[b];
				sdw = tsd[a];
				sdp = tsd[b];
			end
			// selector decides once a frame, well inside the switch time
			if (frame_tick && c.on && c.connection_type) begin
				n.ho_w[i] = (sfw | sdw) ? s.ho_w[i] + 17'(s.ho_w[i] != '1) : '0;
				n.ho_p[i] = (sfp | sdp) ? s.ho_p[i] + 17'(s.ho_p[i] != '1) : '0;
				if (s.ho_w[i] < 17'(c.hold_off_time * HO_STEP_FRAMES)) begin
					sfw = 1'b0;
					sdw = 1'b0;
				end
				if (s.ho_p[i] < 17'(c.hold_off_time * HO_STEP_FRAMES)) begin
					sfp = 1'b0;
					sdp = 1'b0;
				end
				req = 1'b1;
				nsel = c.sel;
				if (c.external_command == xc_pkg::lockout_cmd) begin
					nsel = 1'b0;
				end else if (c.external_command == xc_pkg::forced_switch_cmd) begin
					nsel = c.tgt;
				end else if (sfw != sfp) begin
					nsel = sfw;
				end else if (sdw != sdp) begin
					nsel = sdw;
				end else if (c.external_command == xc_pkg::manual_switch_cmd) begin
					nsel = c.tgt;
				end else begin
					req = 1'b0;
				end
				// non-revertive groups simply stay where they are
				if (req || !c.operation_type || !c.sel) begin
					n.wtr_cnt[i] = '0;
				end else if (s.wtr_cnt[i] + 24'h000001 >=
						24'(c.wait_to_restore_time * WTR_UNIT_FRAMES)) begin
					nsel = 1'b0;
					n.wtr_cnt[i] = '0;
				end else begin
					n.wtr_cnt[i] = s.wtr_cnt[i] + 24'h000001;
				end
				n.conn[i].sel = nsel;
			end
			// new selection takes effect from the frame's first byte
			src_in = (c.connection_type && n.conn[i].sel) ? b : a;
			if (edge_seen) begin
				n.ofs[i] = fs_in;
				if (c.on) begin
					n.od[i] = din[src_in];
					n.ossf[i] = ssf[src_in];
				end else begin
					n.od[i] = 8'h00;
					n.ossf[i] = 1'b0;
				end
			end
		end
		// apb: setup decodes, access completes in one cycle
		setup = psel & ~penable;
		access = psel & penable & s.pready;
		bad = 1'b0;
		case (paddr)
			xc_pkg::CMD_ADDR, xc_pkg::TIMER_ADDR: begin
			end
			xc_pkg::STATUS_ADDR: begin
				for (int i = 0; i < NP; i++) begin
					rd[xc_pkg::ST_SEL_LSB + i] = s.conn[i].sel;
					rd[xc_pkg::ST_ON_LSB + i] = s.conn[i].on;
					rd[xc_pkg::ST_FAULT_LSB + i] = s.ossf[i] & ~s.sink_off[i];
				end
				rd[xc_pkg::ST_REFUSED_BIT] = s.refused;
			end
			xc_pkg::SLOT_ADDR: begin
				rd[xc_pkg::SL_ON_LSB +: NP] = s.slot_on;
				rd[xc_pkg::SL_OWN_LSB +: 2*NP] = s.slot_own;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		n.pready = setup;
		n.pslverr = setup & bad;
		n.prdata = (setup && !pwrite) ? rd : 32'h0000_0000;
		if (access && pwrite && !s.pslverr && paddr == xc_pkg::CMD_ADDR) begin
			o = pwdata[xc_pkg::CMD_OUT_LSB +: 2];
			a = pwdata[xc_pkg::CMD_IN_LSB +: 2];
			b = pwdata[xc_pkg::CMD_PIN_LSB +: 2];
			slot = pwdata[xc_pkg::CMD_SLOT_LSB +: 2];
			own = pwdata[xc_pkg::CMD_OWNER_LSB +: 2];
			case (xc_pkg::op_t'(pwdata[xc_pkg::CMD_OP_LSB +: 3]))
				xc_pkg::op_connect: begin
					// same input kept: timers survive the change, and the selector too unless the connection is made unprotected
					if (!(s.conn[o].on && s.conn[o].src == a)) begin
						n.conn[o] = fresh(a);
					end
					n.conn[o].connection_type = pwdata[xc_pkg::CMD_PROT_BIT];
					n.conn[o].prot_src = b;
					n.conn[o].protection_type =
						xc_pkg::protection_type_t'(pwdata[xc_pkg::CMD_PTYPE_LSB +: 2]);
					n.conn[o].traffic_direction = pwdata[xc_pkg::CMD_BIDIR_BIT];
					if (!pwdata[xc_pkg::CMD_PROT_BIT]) begin
						n.conn[o].sel = 1'b0;
					end
					if (pwdata[xc_pkg::CMD_BIDIR_BIT]) begin
						n.conn[a] = fresh(o);
						if (pwdata[xc_pkg::CMD_PROT_BIT]) begin
							n.conn[b] = fresh(o);
						end
					end
				end
				xc_pkg::op_disconnect: begin
					n.conn[o].on = 1'b0;
				end
				xc_pkg::op_claim: begin
					if (s.slot_on[slot] && s.slot_own[slot] != own) begin
						n.refused = 1'b1;
					end else begin
						n.slot_on[slot] = 1'b1;
						n.slot_own[slot] = own;
						n.refused = 1'b0;
					end
				end
				xc_pkg::op_release: begin
					if (s.slot_on[slot] && s.slot_own[slot] == own) begin
						n.slot_on[slot] = 1'b0;
						n.refused = 1'b0;
					end else begin
						n.refused = 1'b1;
					end
				end
				xc_pkg::op_sink: begin
					n.sink_off[o] = ~pwdata[xc_pkg::CMD_SINK_BIT];
				end
				xc_pkg::op_ext: begin
					// software keeps to the commands legal for the mode
					ext = xc_pkg::external_command_t'(pwdata[xc_pkg::CMD_EXT_LSB +: 3]);
					n.conn[o].external_command =
						(ext == xc_pkg::clear_cmd) ? xc_pkg::ext_none : ext;
					n.conn[o].tgt = pwdata[xc_pkg::CMD_TGT_BIT];
				end
				default: begin
				end
			endcase
		end
		if (access && pwrite && !s.pslverr && paddr == xc_pkg::TIMER_ADDR) begin
			o = pwdata[xc_pkg::TMR_OUT_LSB +: 2];
			// timer changes never touch the selector position
			n.conn[o].hold_off_time =
				(pwdata[xc_pkg::TMR_HO_LSB +: 7] > 7'(xc_pkg::HO_MAX_STEPS))
				? 7'(xc_pkg::HO_MAX_STEPS) : pwdata[xc_pkg::TMR_HO_LSB +: 7];
			n.conn[o].wait_to_restore_time = pwdata[xc_pkg::TMR_WTR_LSB +: 4];
			n.conn[o].operation_type = pwdata[xc_pkg::TMR_REV_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// outputs straight from state
	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign link.out_data = s.od;
	assign link.out_fs = s.ofs;
	assign link.out_ssf = s.ossf;
endmodule

//--- bench/xc_link_assertions.sv
// xc_link_assertions: framing and latency checks on the link between both ends
// assumes pclk samples every link signal and presetn resets both ends together
`timescale 1ns/100ps
module xc_link_assertions #(
	parameter int FRAME_CYCLES = xc_pkg::FRAME_CYCLES
) (
	// clock and reset
	input wire logic                           pclk,
	input wire logic                           presetn,
	// link
	input wire logic                           timing_clock_in,
	input wire logic                           frame_start,
	input wire logic [xc_pkg::N_PORT-1:0][7:0] out_data,
	input wire logic [xc_pkg::N_PORT-1:0]      out_fs
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic        clk_q;
	logic        fs_q;
	logic        seen;
	logic [11:0] bytes;
	logic [15:0] cyc;
	wire         rise = timing_clock_in & ~clk_q;

	// byte and cycle counts per frame; first frame has no predecessor to judge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			fs_q  <= 1'b0;
			seen  <= 1'b0;
			bytes <= 12'h000;
			cyc   <= 16'h0000;
		end else begin
			clk_q <= timing_clock_in;
			fs_q  <= frame_start;
			if (rise)
				bytes <= frame_start ? 12'h001 : bytes + 12'h001;
			if (frame_start && !fs_q) begin
				cyc  <= 16'h0001;
				seen <= 1'b1;
			end else
				cyc <= cyc + 16'h0001;
		end
	end

	sequence byte_shape;
		timing_clock_in[*2] ##1 (!timing_clock_in)[*2];
	endsequence
	sequence fs_byte;
		frame_start[*4] ##1 !frame_start;
	endsequence

	a_byte_shape: assert property ($rose(timing_clock_in) |-> byte_shape)
		else $error("link clock not two high two low");
	a_fs_with_clk: assert property ($rose(frame_start) |-> $rose(timing_clock_in))
		else $error("frame start not on a byte edge");
	a_fs_whole_byte: assert property ($rose(frame_start) |-> fs_byte)
		else $error("frame start not one byte long");
	a_fs_reaches_out: assert property (rise && frame_start |-> ##3 out_fs == '1)
		else $error("output frame start missing");
	a_fs_clears_out: assert property (rise && !frame_start |-> ##3 out_fs == '0)
		else $error("output frame start off byte zero");
	a_out_on_byte: assert property ($changed(out_data) |-> $past(rise, 3))
		else $error("output byte changed off the byte timing");
	a_frame_bytes: assert property (rise && frame_start && bytes != 12'h000 |->
		bytes == 12'(xc_pkg::VC4_BYTES))
		else $error("wrong byte count per frame");
	a_frame_period: assert property ($rose(frame_start) && seen |->
		cyc == 16'(FRAME_CYCLES))
		else $error("wrong frame period");
endmodule

//--- bench/xc_matrix_tb.sv
// xc_matrix_tb: path end and matrix joined by the link, driven over apb and byte streams
// assumes nothing outside; makes pclk and presetn itself
`timescale 1ns/100ps
module xc_matrix_tb;
	localparam int FC    = 9404;
	localparam int LIMIT = 140000;
	localparam int NP    = xc_pkg::N_PORT;
	// clock, reset and apb
	logic               pclk    = 1'b0;
	logic               presetn = 1'b0;
	logic               psel    = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite  = 1'b0;
	logic [31:0]        paddr   = 32'h0;
	logic [31:0]        pwdata  = 32'h0;
	logic               pready;
	logic [31:0]        prdata;
	logic               pslverr;
	// path end user side
	logic [NP-1:0][7:0] src_byte;
	logic [NP-1:0]      ssf = '0;
	logic [NP-1:0]      tsf = '0;
	logic [NP-1:0]      tsd = '0;
	logic               byte_take;
	logic [11:0]        byte_index;
	logic [NP-1:0][7:0] rx_byte;
	logic [NP-1:0]      rx_fs;
	logic [NP-1:0]      rx_ssf;
	logic               rx_valid;
	// bench state
	int                 n_fail = 0;
	int                 samples_checked = 0;
	int                 cyc = 0;
	int                 rxk = 0;
	int                 s;
	int                 a;
	int                 src_of [NP] = '{-1, -1, -1, -1};
	logic [NP-1:0]      chk = '1;
	logic [NP-1:0]      arm = '0;
	logic [31:0]        rnd = 32'h1f7e8a43;
	logic [7:0]         salt = 8'h00;
	logic [31:0]        q;
	logic               e;

	xc_link_if link ();
	xc_path_end #(.FRAME_CYCLES(FC)) i_xc_path_end (.pclk(pclk), .presetn(presetn),
		.link(link), .src_byte(src_byte), .src_server_fail(ssf), .src_trail_fail(tsf),
		.src_trail_degrade(tsd), .byte_take(byte_take), .byte_index(byte_index),
		.rx_byte(rx_byte), .rx_fs(rx_fs), .rx_ssf(rx_ssf), .rx_valid(rx_valid));
	// one frame per step keeps hold-off and wait-to-restore inside the run
	xc_matrix #(.HO_STEP_FRAMES(1), .WTR_UNIT_FRAMES(1)) i_xc_matrix (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .link(link));
	xc_link_assertions #(.FRAME_CYCLES(FC)) i_xc_link_assertions (.pclk(pclk),
		.presetn(presetn), .timing_clock_in(link.timing_clock_in),
		.frame_start(link.frame_start), .out_data(link.out_data), .out_fs(link.out_fs));

	always #(xc_pkg::CLK_PERIOD_NS / 2.0) pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// byte k of input p; the salt comes from the fixed lfsr seed, so every run gets the same pattern
	function automatic logic [7:0] pat(input int k, input int p);
		return 8'(k * 7 + p * 61) ^ salt;
	endfunction
	function automatic logic [31:0] cw(input int op, input int o, input int i, input int pi,
		input int pr);
		return 32'(op) | 32'(o) << xc_pkg::CMD_OUT_LSB | 32'(i) << xc_pkg::CMD_IN_LSB
			| 32'(pi) << xc_pkg::CMD_PIN_LSB | 32'(pr) << xc_pkg::CMD_PROT_BIT;
	endfunction
	function automatic logic [31:0] sc(input int op, input int sl, input int own);
		return cw(op, 0, 0, 0, 0) | 32'(sl) << xc_pkg::CMD_SLOT_LSB
			| 32'(own) << xc_pkg::CMD_OWNER_LSB;
	endfunction

	task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chk_byte(input string n, input logic [7:0] x, input logic [7:0] g);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	// one apb transfer; an idle edge first so psel never changes twice in a step
	task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] ad, input logic [31:0] m, input logic [31:0] x,
		input string n);
		apb(1'b0, ad, 32'h0);
		chk_reg(n, x, q & m);
	endtask
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge pclk);
			while (byte_take !== 1'b1 || byte_index !== 12'h000) @(posedge pclk);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// next byte presented right after each launch; frame start watched on the wire
	always @(posedge pclk) begin
		if (byte_take === 1'b1) begin
			chk_reg("frame_start", 32'(byte_index == 12'h000), 32'(link.frame_start));
			for (int p = 0; p < NP; p++)
				src_byte[p] <= pat(byte_index == 12'(xc_pkg::VC4_BYTES - 1) ? 0
					: int'(byte_index) + 1, p);
		end
	end
	// received bytes against the bench's own routing table; arming waits for byte zero
	always @(posedge pclk) begin
		if (rx_valid === 1'b1) begin
			if (rx_fs[0] === 1'b1) begin
				rxk = 0;
				chk = chk | arm;
				arm = '0;
			end else
				rxk++;
			for (int o = 0; o < NP; o++) begin
				if (chk[o]) begin
					chk_byte("rx_byte", src_of[o] < 0 ? 8'h00 : pat(rxk, src_of[o]), rx_byte[o]);
					if (src_of[o] < 0)
						chk_reg("rx_ssf", 32'h0, 32'(rx_ssf[o]));
				end
			end
		end
	end
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			$display("[ERR] run length expected %0d seen more", LIMIT);
			final_report();
		end
	end

	initial begin
		rnd = lfsr(rnd);
		salt = rnd[7:0];
		s = int'(rnd[9:8]);
		a = int'(rnd[11:10]);
		for (int p = 0; p < NP; p++)
			src_byte[p] = pat(0, p);
		repeat (12) @(posedge pclk);
		chk_reg("out_data", 32'h0, 32'(link.out_data));
		presetn <= 1'b1;
		// registers, unmapped place and slot ownership
		apb(1'b1, 32'h0000_0010, 32'h0);
		chk_reg("pslverr", 32'h1, 32'(e));
		rdchk(xc_pkg::STATUS_ADDR, 32'h0f0, 32'h0, "connected");
		apb(1'b1, xc_pkg::CMD_ADDR, sc(xc_pkg::op_claim, s, a));
		rdchk(xc_pkg::STATUS_ADDR, 32'h1000, 32'h0, "refused");
		apb(1'b1, xc_pkg::CMD_ADDR, sc(xc_pkg::op_claim, s, a ^ 1));
		rdchk(xc_pkg::STATUS_ADDR, 32'h1000, 32'h1000, "refused");
		apb(1'b1, xc_pkg::CMD_ADDR, sc(xc_pkg::op_release, s, a ^ 1));
		rdchk(xc_pkg::STATUS_ADDR, 32'h1000, 32'h1000, "refused");
		rdchk(xc_pkg::SLOT_ADDR, 32'hfff, 32'(1 << s) | 32'(a) << (4 + 2 * s), "slot");
		$display("test registers done");
		// broadcast of input 2, protected output 0; trail fail ignored when inherent
		chk = 4'b0100;
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_connect, 1, 2, 0, 0));
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_connect, 3, 2, 0, 0));
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_connect, 0, 0, 1, 1));
		tsf[0] <= 1'b1;
		src_of = '{0, 2, -1, 2};
		frames(1);
		arm = 4'b1011;
		frames(1);
		rdchk(xc_pkg::STATUS_ADDR, 32'h0ff, 32'h0b0, "connected sel");
		$display("test connect done");
		// hitless changes, fault report and sink suppression
		apb(1'b1, xc_pkg::TIMER_ADDR, 32'h3 | 32'h5 << 8 | 32'h1 << 12 | 32'h1 << 16);
		ssf[2] <= 1'b1;
		repeat (40) @(posedge pclk);
		rdchk(xc_pkg::STATUS_ADDR, 32'hf00, 32'ha00, "fault");
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_sink, 1, 0, 0, 0));
		rdchk(xc_pkg::STATUS_ADDR, 32'hf00, 32'h800, "fault");
		ssf[2] <= 1'b0;
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_connect, 3, 2, 3, 1));
		$display("test hitless done");
		// server fail on working moves output 0 to protection
		chk[0] = 1'b0;
		ssf[0] <= 1'b1;
		frames(2);
		src_of[0] = 1;
		arm = 4'b0001;
		rdchk(xc_pkg::STATUS_ADDR, 32'h00f, 32'h001, "selector");
		$display("test switch done");
		// recovery waits five frames before reverting
		ssf[0] <= 1'b0;
		frames(2);
		rdchk(xc_pkg::STATUS_ADDR, 32'h00f, 32'h001, "wtr hold");
		chk[0] = 1'b0;
		frames(5);
		rdchk(xc_pkg::STATUS_ADDR, 32'h00f, 32'h000, "revert");
		$display("test revert done");
		// lockout pins working despite fail; non-revertive forced goes to protection
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_ext, 0, 0, 0, 0) | 32'h2 << 19);
		ssf[0] <= 1'b1;
		frames(1);
		repeat (4) @(posedge pclk);
		rdchk(xc_pkg::STATUS_ADDR, 32'h00f, 32'h000, "lockout");
		ssf[0] <= 1'b0;
		apb(1'b1, xc_pkg::TIMER_ADDR, 32'h5 << 8);
		apb(1'b1, xc_pkg::CMD_ADDR, cw(xc_pkg::op_ext, 0, 0, 0, 0) | 32'h3 << 19 | 32'h1 << 22);
		frames(1);
		repeat (4) @(posedge pclk);
		rdchk(xc_pkg::STATUS_ADDR, 32'h00f, 32'h001, "forced");
		$display("test commands done");
		final_report();
	end
endmodule
